/* File: common/dcstb_pkg.sv */
package dcstb_pkg;

   localparam int unsigned CLK_HZ = 25_000_000;

   // Times as printed
   localparam int unsigned SKEW_TIMEOUT_S   = 10;
   localparam int unsigned STOP_LIMIT_US    = 20_000;
   localparam int unsigned GLITCH_REJECT_US = 500;

   localparam int unsigned SKEW_TIMEOUT_CYC   = SKEW_TIMEOUT_S * CLK_HZ;
   // Longest time rounds down
   localparam int unsigned STOP_LIMIT_CYC     = (STOP_LIMIT_US * (CLK_HZ / 1_000_000));
   // Pulses of this length or shorter are ignored; one more cycle qualifies
   localparam int unsigned GLITCH_REJECT_CYC  = (GLITCH_REJECT_US * (CLK_HZ / 1_000_000));

   localparam logic [1:0] SON_SRC_PIN      = 2'h0;
   localparam logic [1:0] SON_SRC_ALWAYS   = 2'h1;

   localparam logic [1:0] STOP_DYN_BRAKE      = 2'h0;
   localparam logic [1:0] STOP_DYN_BRAKE_FREE = 2'h1;
   localparam logic [1:0] STOP_COAST          = 2'h2;

   typedef enum logic [1:0] {
      DCSTB_SAFE_BLOCK = 2'b00,
      DCSTB_BASE_BLOCK = 2'b01,
      DCSTB_RUN        = 2'b10
   } dcstb_state_type;

   typedef struct packed {
      logic main_power_on;
      logic servo_alarm;
      logic abs_encoder_used;
      logic absolute_data_request;
   } dcstb_ready_cond_type;

   typedef struct packed {
      logic run_enable;
      logic power_stage_blocked;
      logic hardwired_safe_block;
      logic servo_ready;
      logic brake_release_out;
      logic dynamic_brake_on;
      logic fault_out_n;
      logic alarm_code_enable;
   } dcstb_drive_out_type;

endpackage

/* File: src/dcstb_core.sv */
`timescale 1ns/1ps
`default_nettype none
module dcstb_core #(
   parameter int unsigned SKEW_TIMEOUT_CYC  = dcstb_pkg::SKEW_TIMEOUT_CYC,
   parameter int unsigned GLITCH_REJECT_CYC = dcstb_pkg::GLITCH_REJECT_CYC,
   parameter int unsigned BRAKE_DELAY_W     = 16
) (
   input  wire logic                             core_clk,
   input  wire logic                             rst,
   input  wire logic                             safety_channel_a_n,
   input  wire logic                             safety_channel_b_n,
   input  wire logic                             servo_on_req,
   input  wire logic [1:0]                       servo_on_source_select,
   input  wire logic [1:0]                       stop_method_select,
   input  wire logic [BRAKE_DELAY_W-1:0]         brake_off_delay_setting,
   input  wire dcstb_pkg::dcstb_ready_cond_type  ready_cond,
   input  wire logic                             alarm_reset,
   input  wire logic                             utility_active,
   input  wire logic                             utility_cancel,
   output logic                                  safety_input_skew_alarm,
   output logic                                  utility_motion_allowed,
   output dcstb_pkg::dcstb_drive_out_type        drive_out
);

   dcstb_pkg::dcstb_state_type state_q;
   dcstb_pkg::dcstb_state_type state_d;

   logic                     off_a;
   logic                     off_b;
   logic                     skew_alarm;
   logic                     any_off;
   logic                     servo_on_eff;
   logic                     safe_entry;
   logic                     utility_latched_q;
   logic [BRAKE_DELAY_W-1:0] brake_cnt_q;
   logic                     brake_hold;
   logic                     ready_ok;

   dcstb_off_filter #(
      .REJECT_CYC (GLITCH_REJECT_CYC)
   ) u_filter_a (
      .core_clk (core_clk),
      .rst      (rst),
      .chan_n   (safety_channel_a_n),
      .chan_off (off_a)
   );

   dcstb_off_filter #(
      .REJECT_CYC (GLITCH_REJECT_CYC)
   ) u_filter_b (
      .core_clk (core_clk),
      .rst      (rst),
      .chan_n   (safety_channel_b_n),
      .chan_off (off_b)
   );

   dcstb_skew_timer #(
      .TIMEOUT_CYC (SKEW_TIMEOUT_CYC)
   ) u_skew (
      .core_clk    (core_clk),
      .rst         (rst),
      .off_a       (off_a),
      .off_b       (off_b),
      .alarm_reset (alarm_reset),
      .alarm       (skew_alarm)
   );

   assign any_off = off_a | off_b;

   // Forced-on source means the host can never drop servo-on
   assign servo_on_eff = servo_on_req
                      || (servo_on_source_select == dcstb_pkg::SON_SRC_ALWAYS);

   assign ready_ok = ready_cond.main_power_on
                  && !ready_cond.servo_alarm
                  && !skew_alarm
                  && (!ready_cond.abs_encoder_used || ready_cond.absolute_data_request);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         dcstb_pkg::DCSTB_SAFE_BLOCK: begin
            // Exit only with servo-on released and main power present
            if (!any_off && !servo_on_eff && ready_cond.main_power_on) begin
               state_d = dcstb_pkg::DCSTB_BASE_BLOCK;
            end
         end
         dcstb_pkg::DCSTB_BASE_BLOCK: begin
            if (any_off) begin
               state_d = dcstb_pkg::DCSTB_SAFE_BLOCK;
            end else if (servo_on_eff && ready_ok) begin
               state_d = dcstb_pkg::DCSTB_RUN;
            end
         end
         dcstb_pkg::DCSTB_RUN: begin
            if (any_off) begin
               state_d = dcstb_pkg::DCSTB_SAFE_BLOCK;
            end else if (!servo_on_eff || !ready_ok) begin
               state_d = dcstb_pkg::DCSTB_BASE_BLOCK;
            end
         end
         default: state_d = dcstb_pkg::DCSTB_SAFE_BLOCK;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= dcstb_pkg::DCSTB_SAFE_BLOCK;
      end else begin
         state_q <= state_d;
      end
   end

   assign safe_entry = (state_d == dcstb_pkg::DCSTB_SAFE_BLOCK)
                    && (state_q != dcstb_pkg::DCSTB_SAFE_BLOCK);

   // Utility motion stays locked after a channel turns off during utility operation until cancelled
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         utility_latched_q <= 1'b0;
      end else if (utility_active && any_off) begin
         utility_latched_q <= 1'b1;
      end else if (utility_cancel) begin
         utility_latched_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         utility_motion_allowed <= 1'b0;
      end else begin
         utility_motion_allowed <= utility_active && !utility_latched_q
                                && !(utility_active && any_off)
                                && (state_d == dcstb_pkg::DCSTB_RUN);
      end
   end

   // Normal servo-off holds brake release for the configured delay
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         brake_cnt_q <= '0;
      end else if (state_d == dcstb_pkg::DCSTB_SAFE_BLOCK) begin
         brake_cnt_q <= '0;
      end else if (state_q == dcstb_pkg::DCSTB_RUN && state_d == dcstb_pkg::DCSTB_BASE_BLOCK) begin
         brake_cnt_q <= brake_off_delay_setting;
      end else if (brake_cnt_q != '0) begin
         brake_cnt_q <= brake_cnt_q - BRAKE_DELAY_W'(1);
      end
   end

   assign brake_hold = (state_q == dcstb_pkg::DCSTB_RUN) && (brake_off_delay_setting != '0);

   // Output registers, one per concern; drive_out only gathers them
   logic run_enable_q;
   logic power_stage_blocked_q;
   logic hardwired_safe_block_q;
   logic servo_ready_q;
   logic brake_release_q;
   logic dynamic_brake_q;
   logic fault_out_n_q;
   logic alarm_code_enable_q;

   function automatic logic in_run(input dcstb_pkg::dcstb_state_type s);
      return (s == dcstb_pkg::DCSTB_RUN);
   endfunction

   function automatic logic in_safe(input dcstb_pkg::dcstb_state_type s);
      return (s == dcstb_pkg::DCSTB_SAFE_BLOCK);
   endfunction

   function automatic logic in_base(input dcstb_pkg::dcstb_state_type s);
      return (s == dcstb_pkg::DCSTB_BASE_BLOCK);
   endfunction

   // Both dynamic-brake codes stop the motor on the brake
   function automatic logic dyn_brake_selected(input logic [1:0] method);
      return (method == dcstb_pkg::STOP_DYN_BRAKE)
          || (method == dcstb_pkg::STOP_DYN_BRAKE_FREE);
   endfunction

   function automatic logic alarm_present(input logic servo_alarm,
                                          input logic chan_skew);
      return servo_alarm || chan_skew;
   endfunction

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         run_enable_q <= 1'b0;
      end else begin
         // Both channel terms sit directly in the enable path
         run_enable_q <= in_run(state_d) && !off_a && !off_b && !skew_alarm;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         power_stage_blocked_q <= 1'b1;
      end else begin
         power_stage_blocked_q <= !in_run(state_d);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hardwired_safe_block_q <= 1'b1;
      end else begin
         hardwired_safe_block_q <= in_safe(state_d);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         servo_ready_q <= 1'b0;
      end else begin
         servo_ready_q <= !in_safe(state_d) && ready_ok;
      end
   end

   // A safe-block entry never takes the delayed branch
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         brake_release_q <= 1'b0;
      end else begin
         brake_release_q <= in_run(state_d)
                         || (in_base(state_d)
                             && (brake_cnt_q > BRAKE_DELAY_W'(1)
                                 || (brake_hold && !safe_entry
                                     && brake_cnt_q == '0
                                     && in_run(state_q))));
      end
   end

   // Held from safe-block entry until the next run
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dynamic_brake_q <= 1'b0;
      end else if (safe_entry) begin
         dynamic_brake_q <= dyn_brake_selected(stop_method_select);
      end else if (in_run(state_d)) begin
         dynamic_brake_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fault_out_n_q <= 1'b1;
      end else begin
         fault_out_n_q <= in_safe(state_d)
                       || !alarm_present(ready_cond.servo_alarm, skew_alarm);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alarm_code_enable_q <= 1'b0;
      end else begin
         alarm_code_enable_q <= !in_safe(state_d)
                             && alarm_present(ready_cond.servo_alarm, skew_alarm);
      end
   end

   assign drive_out = '{run_enable:           run_enable_q,
                        power_stage_blocked:  power_stage_blocked_q,
                        hardwired_safe_block: hardwired_safe_block_q,
                        servo_ready:          servo_ready_q,
                        brake_release_out:    brake_release_q,
                        dynamic_brake_on:     dynamic_brake_q,
                        fault_out_n:          fault_out_n_q,
                        alarm_code_enable:    alarm_code_enable_q};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         safety_input_skew_alarm <= 1'b0;
      end else begin
         safety_input_skew_alarm <= skew_alarm;
      end
   end

endmodule // dcstb_core
`default_nettype wire

/* File: src/dcstb_off_filter.sv */
`timescale 1ns/1ps
`default_nettype none
// Debounces one active-low safety channel: OFF is accepted only after it lasts
// longer than the reject window; ON is accepted at once.
module dcstb_off_filter #(
   parameter int unsigned REJECT_CYC = dcstb_pkg::GLITCH_REJECT_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic chan_n,
   output logic      chan_off
);

   localparam int unsigned CW = $clog2(REJECT_CYC + 2);

   logic [CW-1:0] cnt_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (chan_n) begin
         cnt_q <= '0;
      end else if (cnt_q <= CW'(REJECT_CYC)) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         chan_off <= 1'b1;
      end else if (chan_n) begin
         chan_off <= 1'b0;
      end else if (cnt_q >= CW'(REJECT_CYC)) begin
         chan_off <= 1'b1;
      end
   end

endmodule // dcstb_off_filter
`default_nettype wire

/* File: src/dcstb_skew_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Raises a latched alarm when the two filtered channels disagree too long.
module dcstb_skew_timer #(
   parameter int unsigned TIMEOUT_CYC = dcstb_pkg::SKEW_TIMEOUT_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic off_a,
   input  wire logic off_b,
   input  wire logic alarm_reset,
   output logic      alarm
);

   localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

   logic [CW-1:0] cnt_q;
   logic          expired;

   assign expired = (off_a != off_b) && (cnt_q >= CW'(TIMEOUT_CYC - 1));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (off_a == off_b) begin
         cnt_q <= '0;
      end else if (!expired) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // Set wins over the reset request
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alarm <= 1'b0;
      end else if (expired) begin
         alarm <= 1'b1;
      end else if (alarm_reset) begin
         alarm <= 1'b0;
      end
   end

endmodule // dcstb_skew_timer
`default_nettype wire

/* File: verification/dcstb_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dcstb_bench;
   localparam int SKEW = 200;
   logic                            core_clk = 1'b0;
   logic                            rst = 1'b1;
   logic                            want_a, want_b, want_son, cha_n, chb_n, son;
   logic [1:0]                      son_src;
   logic [1:0]                      stop_sel;
   logic                            util_act, util_cancel, allowed;
   logic [2:0]                      rexp;
   logic                            alarm_reset;
   logic                            skew;
   dcstb_pkg::dcstb_ready_cond_type rc;
   dcstb_pkg::dcstb_drive_out_type  dout;
   logic [16:0]                     seed = 17'h148a7;
   int                              miscompares = 0;
   int                              checks = 0;
   wire logic [2:0] blk = {dout.hardwired_safe_block, dout.run_enable, dout.brake_release_out};
   wire logic [2:0] rdy = {dout.fault_out_n, dout.servo_ready, dout.alarm_code_enable};
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   dcstb_safety_unit dcstb_safety_unit_inst (.core_clk(core_clk), .want_a(want_a),
      .want_b(want_b), .want_son(want_son), .chan_a_n(cha_n), .chan_b_n(chb_n),
      .servo_on_req(son));
   dcstb_core #(.SKEW_TIMEOUT_CYC(SKEW), .GLITCH_REJECT_CYC(5)) dcstb_core_inst (
      .core_clk(core_clk), .rst(rst), .safety_channel_a_n(cha_n), .safety_channel_b_n(chb_n),
      .servo_on_req(son), .servo_on_source_select(son_src), .stop_method_select(stop_sel),
      .brake_off_delay_setting(16'h0004), .ready_cond(rc), .alarm_reset(alarm_reset),
      .utility_active(util_act), .utility_cancel(util_cancel), .safety_input_skew_alarm(skew),
      .utility_motion_allowed(allowed), .drive_out(dout));
   function automatic logic [16:0] lfsr_next(input logic [16:0] x);
      return {x[15:0], x[16] ^ x[13]};
   endfunction
   // Servo-ready needs power, no alarm, and absolute data when that encoder is fitted
   function automatic logic ready_exp(input dcstb_pkg::dcstb_ready_cond_type c);
      return c.main_power_on && !c.servo_alarm
          && (!c.abs_encoder_used || c.absolute_data_request);
   endfunction
   task automatic check(input string nm, input logic [2:0] seen, input logic [2:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      int n;
      want_a = 1'b1;
      want_b = 1'b1;
      want_son = 1'b0;
      alarm_reset = 1'b0;
      stop_sel = dcstb_pkg::STOP_DYN_BRAKE;
      util_act = 1'b0;
      util_cancel = 1'b0;
      son_src = dcstb_pkg::SON_SRC_ALWAYS;
      rc = 4'b1000;
      cyc(20);
      rst = 1'b0;
      cyc(10);
      check("forced_son", blk, 3'b100);
      son_src = dcstb_pkg::SON_SRC_PIN;
      cyc(5);
      check("base_block", {1'b0, blk[2], dout.servo_ready}, 3'b001);
      rc.main_power_on = 1'b0;
      cyc(5);
      check("ready_no_power", {2'h0, dout.servo_ready}, 3'b000);
      repeat (6) begin
         seed = lfsr_next(seed);
         rc = seed[3:0];
         rexp = {!rc.servo_alarm, ready_exp(rc), rc.servo_alarm};
         cyc(3);
         check("ready_cond", rdy, rexp);
      end
      rc = 4'b1000;
      want_son = 1'b1;
      cyc(5);
      check("run", blk, 3'b011);
      util_act = 1'b1;
      cyc(2);
      check("util_run", {2'h0, allowed}, 3'b001);
      repeat (4) begin
         seed = lfsr_next(seed);
         want_a = 1'b0;
         cyc(1 + int'(seed[3:0]) % 5);
         want_a = 1'b1;
         cyc(10);
         check("glitch", blk, 3'b011);
      end
      seed = lfsr_next(seed);
      want_a = 1'b0;
      cyc(10 + int'(seed[4:0]));
      check("chan_a_off", blk, 3'b100);
      check("fault_dyn", {1'b0, dout.fault_out_n, dout.dynamic_brake_on}, 3'b011);
      check("util_cut", {2'h0, allowed}, 3'b000);
      want_a = 1'b1;
      cyc(8);
      check("son_still_on", {blk[2], dout.servo_ready, 1'b0}, 3'b100);
      want_son = 1'b0;
      cyc(6);
      check("ready_back", {blk[2], dout.servo_ready, 1'b0}, 3'b010);
      want_son = 1'b1;
      cyc(5);
      check("util_locked", {2'h0, allowed}, 3'b000);
      util_cancel = 1'b1;
      cyc(1);
      util_cancel = 1'b0;
      cyc(2);
      check("util_reentered", {2'h0, allowed}, 3'b001);
      stop_sel = dcstb_pkg::STOP_COAST;
      want_a = 1'b0;
      want_b = 1'b0;
      cyc(9);
      check("both_off", blk, 3'b100);
      check("coast", {1'b0, dout.fault_out_n, dout.dynamic_brake_on}, 3'b010);
      want_son = 1'b0;
      want_a = 1'b1;
      cyc(40);
      n = 0;
      while (skew !== 1'b1 && n < 2 * SKEW) begin
         cyc(1);
         n++;
      end
      if (skew !== 1'b1) begin
         miscompares++;
         complete_run();
      end
      check("skew_late", {1'b0, n + 40 >= SKEW, n + 40 <= SKEW + 4}, 3'b011);
      want_b = 1'b1;
      cyc(10);
      check("skew_latched", {2'h0, skew}, 3'b001);
      alarm_reset = 1'b1;
      cyc(2);
      alarm_reset = 1'b0;
      cyc(2);
      check("skew_cleared", {2'h0, skew}, 3'b000);
      complete_run();
   end
endmodule // dcstb_bench
bind dcstb_core dcstb_chk #(.SKEW_TIMEOUT_CYC(SKEW_TIMEOUT_CYC),
   .GLITCH_REJECT_CYC(GLITCH_REJECT_CYC), .BRAKE_DELAY_W(BRAKE_DELAY_W)) dcstb_chk_inst (
   .core_clk, .rst, .safety_channel_a_n, .safety_channel_b_n, .servo_on_req,
   .servo_on_source_select, .stop_method_select, .brake_off_delay_setting, .ready_cond,
   .alarm_reset, .utility_active, .utility_cancel, .safety_input_skew_alarm,
   .utility_motion_allowed, .drive_out);
`default_nettype wire

/* File: verification/dcstb_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dcstb_chk #(
   parameter int unsigned SKEW_TIMEOUT_CYC  = dcstb_pkg::SKEW_TIMEOUT_CYC,
   parameter int unsigned GLITCH_REJECT_CYC = dcstb_pkg::GLITCH_REJECT_CYC,
   parameter int unsigned BRAKE_DELAY_W     = 16
) (
   input wire logic                           core_clk,
   input wire logic                           rst,
   input wire logic                           safety_channel_a_n,
   input wire logic                           safety_channel_b_n,
   input wire logic                           servo_on_req,
   input wire logic [1:0]                     servo_on_source_select,
   input wire logic [1:0]                     stop_method_select,
   input wire logic [BRAKE_DELAY_W-1:0]       brake_off_delay_setting,
   input wire dcstb_pkg::dcstb_ready_cond_type ready_cond,
   input wire logic                           alarm_reset,
   input wire logic                           utility_active,
   input wire logic                           utility_cancel,
   input wire logic                           safety_input_skew_alarm,
   input wire logic                           utility_motion_allowed,
   input wire dcstb_pkg::dcstb_drive_out_type  drive_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_chan_a;
      !safety_channel_a_n [*8] |=> !drive_out.run_enable;
   endproperty
   a_chan_a: assert property (p_chan_a) else $error("run kept, channel a off");
   property p_chan_b;
      !safety_channel_b_n [*8] |=> drive_out.hardwired_safe_block;
   endproperty
   a_chan_b: assert property (p_chan_b) else $error("no block, channel b off");
   property p_son_hold;
      drive_out.hardwired_safe_block && servo_on_req && $past(servo_on_req)
         |=> drive_out.hardwired_safe_block;
   endproperty
   a_son_hold: assert property (p_son_hold) else $error("block left with servo on");
   property p_blk_outs;
      drive_out.hardwired_safe_block |-> !drive_out.servo_ready && !drive_out.run_enable;
   endproperty
   a_blk_outs: assert property (p_blk_outs) else $error("ready or run in block");
   property p_brake;
      $rose(drive_out.hardwired_safe_block) |-> !drive_out.brake_release_out;
   endproperty
   a_brake: assert property (p_brake) else $error("brake held on block entry");
   property p_dyn;
      $rose(drive_out.hardwired_safe_block) && stop_method_select < 2'h2
         |-> drive_out.dynamic_brake_on;
   endproperty
   a_dyn: assert property (p_dyn) else $error("no dynamic brake on entry");
   property p_coast;
      $rose(drive_out.hardwired_safe_block) && stop_method_select >= 2'h2
         |-> !drive_out.dynamic_brake_on;
   endproperty
   a_coast: assert property (p_coast) else $error("dynamic brake in coast mode");
   property p_no_fault;
      drive_out.hardwired_safe_block |-> drive_out.fault_out_n && !drive_out.alarm_code_enable;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault issued in block");
   property p_alarm;
      safety_input_skew_alarm |-> !drive_out.run_enable ##1 ($fell(safety_input_skew_alarm)
         -> $past(alarm_reset, 2));
   endproperty
   a_alarm: assert property (p_alarm) else $error("skew alarm run or release");
endmodule // dcstb_chk
`default_nettype wire

/* File: verification/dcstb_safety_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Safety unit and host: lines follow requests one edge later
module dcstb_safety_unit (
   input  wire logic core_clk,
   input  wire logic want_a,
   input  wire logic want_b,
   input  wire logic want_son,
   output var  logic chan_a_n = 1'b0,
   output var  logic chan_b_n = 1'b0,
   output var  logic servo_on_req = 1'b0
);
   always @(posedge core_clk) begin
      chan_a_n     <= #1 want_a;
      chan_b_n     <= #1 want_b;
      servo_on_req <= #1 want_son;
   end
endmodule // dcstb_safety_unit
`default_nettype wire
